// >>> hw/rxb_regs.sv
`timescale 1ns/1ps
`include "rxb_cfg.svh"

module rxb_regs
(
  // Clock and reset
  input  wire logic                  i_core_clk,
  input  wire logic                  i_srst,
  // Avalon-MM slave
  input  wire logic [9:0]            i_avs_address,
  input  wire logic                  i_avs_read,
  input  wire logic                  i_avs_write,
  input  wire logic [31:0]           i_avs_writedata,
  output logic [31:0]                o_avs_readdata,
  output logic                       o_avs_waitrequest,
  // Receiver events
  input  wire logic                  i_link_lock,
  input  wire logic                  i_parity_err,
  input  wire logic                  i_selftest_start,
  input  wire logic                  i_selftest_err,
  input  wire logic                  i_camera_mode,
  // Remote serializer identity from the link
  input  wire logic                  i_ident_valid,
  input  wire logic [6:0]            i_ident_data,
  // I2C request qualifiers
  input  wire logic                  i_i2c_req,
  input  wire logic                  i_i2c_write,
  input  wire logic                  i_i2c_addr_match,
  // I2C decisions
  output logic                       o_i2c_forward,
  output logic                       o_i2c_local_ack,
  // Back-channel controls
  output logic                       o_bc_enable,
  output logic                       o_bc_crc_en,
  output rxb_pkg::rxb_rate_t         o_bc_rate_sel,
  output logic                       o_bc_bit_tick,
  output logic                       o_bc_settling,
  // Status
  output logic                       o_parity_check_en,
  output logic                       o_parity_over,
  output logic [6:0]                 o_remote_ident,
  output logic                       o_irq
);

  import rxb_pkg::*;

  // ****************************************************************
  // Timing constants
  // ****************************************************************

  localparam int FAST_DIV   = `RXB_BIT_FAST_PS / `RXB_CLK_PS;
  localparam int SLOW_DIV   = `RXB_BIT_SLOW_PS / `RXB_CLK_PS;
  localparam int SETTLE_CYC = (`RXB_SETTLE_NS * 1000 + `RXB_CLK_PS - 1) / `RXB_CLK_PS;

  localparam logic [7:0]  FAST_LAST   = 8'(FAST_DIV - 1);
  localparam logic [7:0]  SLOW_LAST   = 8'(SLOW_DIV - 1);
  localparam logic [11:0] SETTLE_LAST = 12'(SETTLE_CYC - 1);

  // ****************************************************************
  // Storage
  // ****************************************************************

  rxb_byte_t    bc_cfg;
  rxb_byte_t    rsv_a;
  rxb_byte_t    rsv_b;
  rxb_byte_t    ident;
  rxb_par_cnt_t thresh;
  logic [3:0]   irq_sts;
  logic [3:0]   irq_mask;
  logic         par_en;
  logic         ack_q;
  logic         lock_q;
  logic         over_q;
  logic [7:0]   div_cnt;
  logic [11:0]  settle_cnt;
  rxb_par_cnt_t par_cnt;
  rxb_byte_t    st_cnt;

  // ****************************************************************
  // Bus decode
  // ****************************************************************

  wire logic [7:0] idx;
  wire logic       aligned;
  wire logic       req;
  wire logic       take;
  wire logic       wr_acc;
  wire logic       rd_snap;
  wire rxb_byte_t  wdat;

  assign idx     = i_avs_address[9:2];
  assign aligned = (i_avs_address[1:0] == 2'b00);
  assign req     = i_avs_read || i_avs_write;
  // The first cycle of a request captures read data; the second releases the master.
  assign take    = req && !ack_q;
  assign wr_acc  = i_avs_write && ack_q && aligned;
  assign rd_snap = i_avs_read && take && aligned;
  assign wdat    = i_avs_writedata[7:0];

  assign o_avs_waitrequest = req && !ack_q;

  wire logic wr_bc;
  wire logic wr_rsv_a;
  wire logic wr_rsv_b;
  wire logic wr_ident;
  wire logic wr_thr_lo;
  wire logic wr_thr_hi;
  wire logic wr_sts;
  wire logic wr_mask;
  wire logic wr_ctrl;
  wire logic rd_par_lo;

  assign wr_bc     = wr_acc && (idx == `RXB_IDX_BC_CFG);
  assign wr_rsv_a  = wr_acc && (idx == `RXB_IDX_RSV_A);
  assign wr_rsv_b  = wr_acc && (idx == `RXB_IDX_RSV_B);
  assign wr_ident  = wr_acc && (idx == `RXB_IDX_IDENT);
  assign wr_thr_lo = wr_acc && (idx == `RXB_IDX_THR_LO);
  assign wr_thr_hi = wr_acc && (idx == `RXB_IDX_THR_HI);
  assign wr_sts    = wr_acc && (idx == `RXB_IDX_IRQ_STS);
  assign wr_mask   = wr_acc && (idx == `RXB_IDX_IRQ_MASK);
  assign wr_ctrl   = wr_acc && (idx == `RXB_IDX_CTRL);
  assign rd_par_lo = rd_snap && (idx == `RXB_IDX_PAR_LO);

  // ****************************************************************
  // Counters
  // ****************************************************************

  wire logic lock_rise;
  wire logic par_clr;

  assign lock_rise = i_link_lock && !lock_q;
  assign par_clr   = lock_rise || rd_par_lo;

  rxb_sat_counter #(.WIDTH(16)) u_par_cnt
  (
    .i_core_clk (i_core_clk),
    .i_srst     (i_srst),
    .i_clr      (par_clr),
    .i_inc      (i_parity_err && par_en),
    .o_count    (par_cnt)
  );

  rxb_sat_counter #(.WIDTH(8)) u_st_cnt
  (
    .i_core_clk (i_core_clk),
    .i_srst     (i_srst),
    .i_clr      (i_selftest_start),
    .i_inc      (i_selftest_err),
    .o_count    (st_cnt)
  );

  // ****************************************************************
  // Read mux
  // ****************************************************************

  wire rxb_byte_t rd_byte;

  assign rd_byte =
      (idx == `RXB_IDX_PAR_HI)   ? par_cnt[15:8] :
      (idx == `RXB_IDX_PAR_LO)   ? par_cnt[7:0] :
      (idx == `RXB_IDX_ST_ERR)   ? st_cnt :
      (idx == `RXB_IDX_BC_CFG)   ? bc_cfg :
      (idx == `RXB_IDX_RSV_A)    ? rsv_a :
      (idx == `RXB_IDX_RSV_B)    ? rsv_b :
      (idx == `RXB_IDX_IDENT)    ? ident :
      (idx == `RXB_IDX_THR_LO)   ? thresh[7:0] :
      (idx == `RXB_IDX_THR_HI)   ? thresh[15:8] :
      (idx == `RXB_IDX_IRQ_STS)  ? {4'h0, irq_sts} :
      (idx == `RXB_IDX_IRQ_MASK) ? {4'h0, irq_mask} :
      (idx == `RXB_IDX_CTRL)     ? {6'h00, over_q, par_en} :
      8'h00;

  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
      o_avs_readdata <= 32'h0000_0000;
    else if (i_avs_read && take)
      o_avs_readdata <= {24'h00_0000, aligned ? rd_byte : 8'h00};
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
      ack_q <= 1'b0;
    else
      ack_q <= take;
  end

  // ****************************************************************
  // Configuration registers
  // ****************************************************************

  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
    begin
      bc_cfg   <= `RXB_RST_BC_CFG;
      rsv_a    <= 8'h00;
      rsv_b    <= 8'h00;
      thresh   <= `RXB_RST_THR;
      irq_mask <= 4'h0;
      par_en   <= `RXB_RST_CTRL;
    end
    else
    begin
      if (wr_bc)
        bc_cfg <= wdat;
      if (wr_rsv_a)
        rsv_a <= wdat;
      if (wr_rsv_b)
        rsv_b <= wdat;
      if (wr_thr_lo)
        thresh[7:0] <= wdat;
      if (wr_thr_hi)
        thresh[15:8] <= wdat;
      if (wr_mask)
        irq_mask <= wdat[3:0];
      if (wr_ctrl)
        par_en <= wdat[`RXB_CTRL_PAR_EN];
    end
  end

  // ****************************************************************
  // Remote serializer identity
  // ****************************************************************

  wire logic auto_load;

  assign auto_load = i_ident_valid && !ident[0] && !wr_ident;

  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
      ident <= `RXB_RST_IDENT;
    else if (wr_ident)
      ident <= wdat;
    else if (auto_load)
      ident[7:1] <= i_ident_data;
  end

  // ****************************************************************
  // Threshold flag and interrupts
  // ****************************************************************

  wire logic [3:0] irq_evt;
  wire logic [3:0] next_irq_sts;

  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
    begin
      over_q <= 1'b0;
      lock_q <= 1'b0;
    end
    else
    begin
      over_q <= (par_cnt > thresh) && !par_clr;
      lock_q <= i_link_lock;
    end
  end

  assign irq_evt[`RXB_IRQ_OVER]   = (par_cnt > thresh) && !over_q && !par_clr;
  assign irq_evt[`RXB_IRQ_IDENT]  = auto_load && (ident[7:1] != i_ident_data);
  assign irq_evt[`RXB_IRQ_ST_ERR] = i_selftest_err;
  assign irq_evt[`RXB_IRQ_LOCK]   = lock_rise;

  // A new event wins over a write-one-to-clear in the same cycle.
  assign next_irq_sts = (irq_sts & ~(wr_sts ? wdat[3:0] : 4'h0)) | irq_evt;

  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
      irq_sts <= 4'h0;
    else
      irq_sts <= next_irq_sts;
  end

  assign o_irq = |(irq_sts & irq_mask);

  // ****************************************************************
  // Back-channel bit rate and settling window
  // ****************************************************************

  wire logic       rate_chg;
  wire logic [7:0] div_last;

  assign div_last = (bc_cfg[1:0] == RXB_RATE_SLOW) ? SLOW_LAST : FAST_LAST;
  assign rate_chg = wr_bc && (wdat[1:0] != bc_cfg[1:0]);

  always_ff @(posedge i_core_clk)
  begin
    if (i_srst || rate_chg || div_cnt >= div_last)
      div_cnt <= 8'h00;
    else
      div_cnt <= div_cnt + 8'h01;
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
      o_bc_bit_tick <= 1'b0;
    else
      o_bc_bit_tick <= !rate_chg && (div_cnt >= div_last);
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
      settle_cnt <= 12'h000;
    else if (rate_chg)
      settle_cnt <= SETTLE_LAST + 12'h001;
    else if (settle_cnt != 12'h000)
      settle_cnt <= settle_cnt - 12'h001;
  end

  // ****************************************************************
  // Registered outputs
  // ****************************************************************

  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
    begin
      o_i2c_forward   <= 1'b0;
      o_i2c_local_ack <= 1'b0;
      o_bc_enable     <= 1'b1;
      o_bc_crc_en     <= 1'b1;
      o_bc_rate_sel   <= RXB_RATE_FAST;
      o_bc_settling   <= 1'b0;
    end
    else
    begin
      o_i2c_forward   <= i_i2c_req && (bc_cfg[`RXB_BC_PASS_ALL]
                         || (bc_cfg[`RXB_BC_PASS_MATCH] && i_i2c_addr_match));
      o_i2c_local_ack <= i_i2c_req && i_i2c_write && bc_cfg[`RXB_BC_AUTO_ACK];
      o_bc_enable     <= !i_camera_mode || bc_cfg[`RXB_BC_CAM_EN];
      o_bc_crc_en     <= bc_cfg[`RXB_BC_CRC_EN];
      o_bc_rate_sel   <= rxb_rate_t'(bc_cfg[1:0]);
      o_bc_settling   <= rate_chg || (settle_cnt > 12'h001);
    end
  end

  assign o_parity_check_en = par_en;
  assign o_parity_over     = over_q;
  assign o_remote_ident    = ident[7:1];

endmodule

// >>> hw/rxb_cfg.svh
`ifndef RXB_CFG_SVH
`define RXB_CFG_SVH

// Register indices; the Avalon byte address is four times the index.
`define RXB_IDX_PAR_HI      8'h55
`define RXB_IDX_PAR_LO      8'h56
`define RXB_IDX_ST_ERR      8'h57
`define RXB_IDX_BC_CFG      8'h58
`define RXB_IDX_RSV_A       8'h59
`define RXB_IDX_RSV_B       8'h5a
`define RXB_IDX_IDENT       8'h5b
`define RXB_IDX_THR_LO      8'h70
`define RXB_IDX_THR_HI      8'h71
`define RXB_IDX_IRQ_STS     8'h72
`define RXB_IDX_IRQ_MASK    8'h73
`define RXB_IDX_CTRL        8'h74

// Field positions.
`define RXB_BC_PASS_ALL     7
`define RXB_BC_PASS_MATCH   6
`define RXB_BC_AUTO_ACK     5
`define RXB_BC_CAM_EN       4
`define RXB_BC_CRC_EN       3
`define RXB_IRQ_OVER        0
`define RXB_IRQ_IDENT       1
`define RXB_IRQ_ST_ERR      2
`define RXB_IRQ_LOCK        3
`define RXB_CTRL_PAR_EN     0
`define RXB_CTRL_OVER       1

// Reset values.
`define RXB_RST_BC_CFG      8'h18
`define RXB_RST_IDENT       8'h00
`define RXB_RST_THR         16'hffff
`define RXB_RST_CTRL        1'b1

// Timing: clock period and back-channel bit periods.
`define RXB_CLK_PS          5000
`define RXB_BIT_FAST_PS     400000
`define RXB_BIT_SLOW_PS     640000
`define RXB_SETTLE_NS       2000

`endif

// >>> hw/rxb_pkg.sv
package rxb_pkg;

  typedef logic [7:0]  rxb_byte_t;
  typedef logic [15:0] rxb_par_cnt_t;

  typedef enum logic [1:0]
  {
    RXB_RATE_FAST = 2'b00,
    RXB_RATE_SLOW = 2'b01,
    RXB_RATE_RSV2 = 2'b10,
    RXB_RATE_RSV3 = 2'b11
  } rxb_rate_t;

endpackage

// >>> hw/rxb_sat_counter.sv
`timescale 1ns/1ps

module rxb_sat_counter
#(
  parameter int WIDTH = 8
)
(
  // Clock and reset
  input  wire logic             i_core_clk,
  input  wire logic             i_srst,
  // Control
  input  wire logic             i_clr,
  input  wire logic             i_inc,
  // Count
  output logic [WIDTH-1:0]      o_count
);

  wire logic             at_max;
  wire logic [WIDTH-1:0] next_count;

  // A clear and an event in the same cycle leave a count of one, so the event is kept.
  assign at_max     = &o_count;
  assign next_count = i_clr ? {{(WIDTH-1){1'b0}}, i_inc}
                    : ((i_inc && !at_max) ? o_count + 1'b1 : o_count);

  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
      o_count <= '0;
    else
      o_count <= next_count;
  end

endmodule

// >>> dv/rxb_regs_props.sv
`timescale 1ns/1ps
module rxb_regs_props
(
  // Clock and reset
  input wire logic               i_core_clk,
  input wire logic               i_srst,
  // Bus
  input wire logic [9:0]         i_avs_address,
  input wire logic               i_avs_read,
  input wire logic               i_avs_write,
  input wire logic [31:0]        i_avs_writedata,
  input wire logic               o_avs_waitrequest,
  // Events
  input wire logic               i_camera_mode,
  input wire logic               i_ident_valid,
  input wire logic               i_i2c_req,
  input wire logic               i_i2c_write,
  // Outputs
  input wire logic               o_i2c_forward,
  input wire logic               o_i2c_local_ack,
  input wire logic               o_bc_enable,
  input wire logic               o_bc_crc_en,
  input wire rxb_pkg::rxb_rate_t o_bc_rate_sel,
  input wire logic               o_bc_bit_tick,
  input wire logic               o_bc_settling,
  input wire logic               o_parity_over,
  input wire logic [6:0]         o_remote_ident
);
  import rxb_pkg::*;
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_srst);
  int unsigned scnt;
  wire logic   rate_wr;
  // A rate change during settling restarts the window, so the length count restarts too.
  assign rate_wr = i_avs_write && !o_avs_waitrequest && i_avs_address == 10'h160
                   && i_avs_writedata[1:0] != o_bc_rate_sel;
  // A rate change inside a tick window raises settling, so the period checks excuse it.
  always_ff @(posedge i_core_clk)
  begin
    if (i_srst || !o_bc_settling || rate_wr)
      scnt <= 0;
    else
      scnt <= scnt + 1;
  end
  property cfg_p;
    logic [7:0] d;
    (i_avs_write && !o_avs_waitrequest && i_avs_address == 10'h160, d = i_avs_writedata[7:0])
      |=> ##1 o_bc_crc_en == d[3] && o_bc_rate_sel == d[1:0];
  endproperty
  chk_wait_once: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
    else $error("waitrequest held too long");
  chk_fwd_cause: assert property (o_i2c_forward |-> $past(i_i2c_req))
    else $error("forward without request");
  chk_ack_cause: assert property (o_i2c_local_ack |-> $past(i_i2c_req) && $past(i_i2c_write))
    else $error("local ack without write");
  chk_display_bc: assert property ($past(i_camera_mode) == 1'b0 |-> o_bc_enable)
    else $error("back channel off in display mode");
  chk_cfg_apply: assert property (cfg_p)
    else $error("config write not applied");
  chk_tick_fast: assert property (o_bc_bit_tick && o_bc_rate_sel != RXB_RATE_SLOW |-> ##80 (o_bc_bit_tick || o_bc_settling))
    else $error("fast tick period wrong");
  chk_tick_slow: assert property (o_bc_bit_tick && o_bc_rate_sel == RXB_RATE_SLOW |-> ##128 (o_bc_bit_tick || o_bc_settling))
    else $error("slow tick period wrong");
  chk_settle_len: assert property ($fell(o_bc_settling) |-> scnt == 400)
    else $error("settling length wrong");
  chk_ident_cause: assert property ($changed(o_remote_ident) |-> $past(i_ident_valid) || $past(i_avs_write))
    else $error("ident changed without cause");
  chk_over_clear: assert property (i_avs_read && o_avs_waitrequest && i_avs_address == 10'h158 |=> ##1 !o_parity_over)
    else $error("over flag survived clear");
  cov_fwd: cover property (o_i2c_forward);
  cov_ack: cover property (o_i2c_local_ack);
  cov_settle: cover property ($fell(o_bc_settling));
endmodule
bind rxb_regs rxb_regs_props rxb_regs_props_i (.i_core_clk(i_core_clk), .i_srst(i_srst),
  .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
  .i_avs_writedata(i_avs_writedata), .o_avs_waitrequest(o_avs_waitrequest), .i_camera_mode(i_camera_mode),
  .i_ident_valid(i_ident_valid), .i_i2c_req(i_i2c_req), .i_i2c_write(i_i2c_write),
  .o_i2c_forward(o_i2c_forward), .o_i2c_local_ack(o_i2c_local_ack), .o_bc_enable(o_bc_enable),
  .o_bc_crc_en(o_bc_crc_en), .o_bc_rate_sel(o_bc_rate_sel), .o_bc_bit_tick(o_bc_bit_tick),
  .o_bc_settling(o_bc_settling), .o_parity_over(o_parity_over), .o_remote_ident(o_remote_ident));

// >>> dv/rxb_remote_ser.sv
`timescale 1ns/1ps
module rxb_remote_ser
(
  // Clock
  input  wire logic       i_core_clk,
  // Bench commands
  input  wire logic       i_send_ident,
  input  wire logic [6:0] i_ident,
  input  wire logic       i_send_err,
  // Link side
  output logic            o_ident_valid,
  output logic [6:0]      o_ident_data,
  output logic            o_parity_err
);
  // ID frames and parity errors
  // Between frames the ID lines toggle, so a stale value is never a valid one.
  always_ff @(posedge i_core_clk)
  begin
    o_ident_valid <= i_send_ident;
    o_ident_data  <= i_send_ident ? i_ident : ~o_ident_data;
    o_parity_err  <= i_send_err;
  end
endmodule

// >>> dv/rxb_regs_test.sv
`timescale 1ns/1ps
module rxb_regs_test;
  import rxb_pkg::*;
  logic clk = 0, srst = 1, rd = 0, wr = 0, lock = 0, st_go = 0, st_err = 0, cam = 1;
  logic snd_id = 0, snd_err = 0, req = 0, i2w = 0, amat = 0, idv, perr;
  logic [9:0] adr = 0;
  logic [31:0] wd = 0, rdata;
  logic [6:0] idd, idw = 0, rid;
  logic fwd, lack, bce, crc, tick, setl, pce, over, irq, wreq;
  rxb_rate_t rsel;
  int miscompares = 0, comparisons = 0, cyc = 0;
  rxb_regs rxb_regs_i (.i_core_clk(clk), .i_srst(srst), .i_avs_address(adr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wd), .o_avs_readdata(rdata), .o_avs_waitrequest(wreq),
    .i_link_lock(lock), .i_parity_err(perr), .i_selftest_start(st_go), .i_selftest_err(st_err),
    .i_camera_mode(cam), .i_ident_valid(idv), .i_ident_data(idd), .i_i2c_req(req), .i_i2c_write(i2w),
    .i_i2c_addr_match(amat), .o_i2c_forward(fwd), .o_i2c_local_ack(lack), .o_bc_enable(bce),
    .o_bc_crc_en(crc), .o_bc_rate_sel(rsel), .o_bc_bit_tick(tick), .o_bc_settling(setl),
    .o_parity_check_en(pce), .o_parity_over(over), .o_remote_ident(rid), .o_irq(irq));
  rxb_remote_ser rxb_remote_ser_i (.i_core_clk(clk), .i_send_ident(snd_id), .i_ident(idw),
    .i_send_err(snd_err), .o_ident_valid(idv), .o_ident_data(idd), .o_parity_err(perr));
  initial
    forever #2.5 clk = ~clk;
  task automatic chk(input logic [7:0] g, input logic [7:0] e, input string m);
    comparisons++;
    if (g !== e)
    begin
      miscompares++;
      $display("unexpected at %0t: %s got %h want %h", $time, m, g, e);
    end
  endtask
  // Holds the request until waitrequest is sampled low at a rising edge, then releases it there.
  task automatic bus(input logic w, input logic [7:0] i, input logic [7:0] d, output logic [7:0] q);
    int n;
    @(posedge clk);
    rd <= !w;
    wr <= w;
    adr <= {i, 2'b00};
    wd <= {24'h0, d};
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (wreq !== 1'b0 && n < 50);
    q = rdata[7:0];
    rd <= 0;
    wr <= 0;
    if (n >= 50)
      chk(1'b0, 1'b1, "bus hang");
    @(negedge clk);
  endtask
  task automatic wr8(input logic [7:0] i, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, i, d, q);
  endtask
  task automatic rd8(input logic [7:0] i, input logic [7:0] e, input string m);
    logic [7:0] q;
    bus(1'b0, i, 8'h00, q);
    chk(q, e, m);
  endtask
  task automatic errs(input int n);
    @(posedge clk);
    snd_err <= 1;
    repeat (n) @(posedge clk);
    snd_err <= 0;
    repeat (3) @(posedge clk);
  endtask
  task automatic i2c(input logic w, input logic m, input logic ef, input logic ea);
    @(posedge clk);
    req <= 1;
    i2w <= w;
    amat <= m;
    @(posedge clk);
    req <= 0;
    @(negedge clk);
    chk(fwd, ef, "forward");
    chk(lack, ea, "local ack");
  endtask
  task automatic period(input int e, input string m);
    int n;
    n = 0;
    while (tick !== 1'b1 && n < 300)
    begin
      @(negedge clk);
      n++;
    end
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
    end
    while (tick !== 1'b1 && n < 300);
    chk(n, e, m);
  endtask
  task automatic send(input logic [6:0] v);
    @(posedge clk);
    snd_id <= 1;
    idw <= v;
    @(posedge clk);
    snd_id <= 0;
    repeat (2) @(posedge clk);
  endtask
  task automatic t_reset();
    rd8(8'h55, 8'h00, "par hi");
    rd8(8'h56, 8'h00, "par lo");
    rd8(8'h58, 8'h18, "bc cfg");
    rd8(8'h5b, 8'h00, "ident");
    wr8(8'h57, 8'hff);
    rd8(8'h57, 8'h00, "ro selftest");
    wr8(8'h55, 8'hff);
    rd8(8'h55, 8'h00, "ro par");
    wr8(8'h59, 8'ha5);
    rd8(8'h59, 8'ha5, "reserved rw");
    rd8(8'h20, 8'h00, "unmapped");
    chk(rsel, 2'b00, "rate");
    chk(pce, 1'b1, "checker on");
  endtask
  task automatic t_parity();
    errs(300);
    rd8(8'h55, 8'h01, "hi 300");
    rd8(8'h56, 8'h2c, "lo 300");
    rd8(8'h55, 8'h00, "hi cleared");
    wr8(8'h70, 8'h02);
    wr8(8'h71, 8'h00);
    wr8(8'h73, 8'h01);
    errs(3);
    chk(over, 1'b1, "over");
    chk(irq, 1'b1, "irq");
    rd8(8'h74, 8'h03, "ctrl flag");
    wr8(8'h74, 8'h00);
    chk(pce, 1'b0, "checker off");
    errs(2);
    rd8(8'h56, 8'h03, "paused lo");
    chk(over, 1'b0, "over cleared");
    wr8(8'h72, 8'h01);
    chk(irq, 1'b0, "irq cleared");
    wr8(8'h74, 8'h01);
    errs(5);
    lock <= 1;
    rd8(8'h56, 8'h00, "lock clears");
  endtask
  task automatic t_i2c();
    logic [7:0] c;
    for (int k = 0; k < 8; k++)
    begin
      c = {k[2:0], 5'h18};
      wr8(8'h58, c);
      i2c(1'b1, 1'b0, c[7], c[5]);
      i2c(1'b0, 1'b1, c[7] | c[6], 1'b0);
    end
    wr8(8'h58, 8'h00);
    repeat (2) @(negedge clk);
    chk(bce, 1'b0, "camera off");
    chk(crc, 1'b0, "crc off");
    @(posedge clk);
    cam <= 0;
    repeat (2) @(negedge clk);
    chk(bce, 1'b1, "display");
    @(posedge clk);
    cam <= 1;
  endtask
  task automatic t_rate();
    int n;
    wr8(8'h58, 8'h38);
    wr8(8'h58, 8'h39);
    repeat (2) @(negedge clk);
    chk(rsel, 2'b01, "rate slow");
    n = 0;
    while (setl === 1'b1 && n < 500)
    begin
      @(negedge clk);
      n++;
    end
    chk(n > 390 && n <= 400, 1'b1, "settle");
    period(128, "slow");
    wr8(8'h58, 8'h3a);
    repeat (200) @(negedge clk);
    period(80, "reserved");
    wr8(8'h58, 8'h38);
    repeat (200) @(negedge clk);
    period(80, "fast");
  endtask
  task automatic t_ident();
    wr8(8'h72, 8'hff);
    wr8(8'h73, 8'h06);
    send(7'h2a);
    rd8(8'h5b, 8'h54, "auto id");
    chk(rid, 7'h2a, "id port");
    chk(irq, 1'b1, "id irq");
    wr8(8'h72, 8'h02);
    chk(irq, 1'b0, "irq w1c");
    wr8(8'h5b, 8'h33);
    send(7'h7f);
    rd8(8'h5b, 8'h33, "frozen id");
    chk(rid, 7'h19, "frozen port");
    @(posedge clk);
    st_go <= 1;
    @(posedge clk);
    st_go <= 0;
    st_err <= 1;
    repeat (2) @(posedge clk);
    st_err <= 0;
    rd8(8'h57, 8'h02, "selftest count");
    rd8(8'h72, 8'h04, "selftest status");
    chk(irq, 1'b1, "selftest irq");
    wr8(8'h73, 8'h00);
    chk(irq, 1'b0, "masked");
  endtask
  task automatic test_done();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      miscompares++;
      test_done();
    end
  end
  initial
  begin
    repeat (5) @(posedge clk);
    srst <= 0;
    t_reset();
    t_parity();
    t_i2c();
    t_rate();
    t_ident();
    test_done();
  end
endmodule
